// file: hw/kcr_pkg.sv
// kcr_pkg: constants for the key-combination initial reset block
// assumes pclk at 200 MHz and a 32.768 kHz oscillator on a pin
// Functional notes
// - reset when selected port0 pins all high
// - combo passes 1.5 ms noise filter
// - filter counts only after oscillator starts
// - four options: off, two, three, four pins
// - unselected pins ignored for options two, three
// - optional hold qualifier of one second
// - program counter loads 0110H on reset
// - interrupt and extension flags cleared
// - interrupts masked until both stack pointers written
// - extension register write sets extension flag
// - shared pins reset to plain inputs
// - reset inputs pulled down per option
// - port3 carries serial interface when selected
// - timer, buzzer, clock, counters, stopwatch, converter routing
// - latch released only on 16 Hz pulse
// - 21515 oscillator periods of init before run
package kcr_pkg;
  // timing base
  localparam int unsigned PCLK_MHZ = 200;
  localparam int unsigned OSC_HZ = 32768;
  localparam int unsigned SLOW_HZ = 16;
  localparam logic [10:0] DIV_LAST = 11'(OSC_HZ / SLOW_HZ - 1);
  localparam int unsigned FILT_US = 1500;
  localparam logic [5:0] FILT_TICKS = 6'((FILT_US * OSC_HZ + 999999) / 1000000);
  localparam int unsigned HOLD_SEC = 1;
  localparam logic [4:0] HOLD_PULSES = 5'(HOLD_SEC * SLOW_HZ);
  localparam int unsigned INIT_OSC = 21515;
  localparam logic [14:0] INIT_LAST = 15'(INIT_OSC - 1);
  localparam int unsigned RST_NS = 100;
  localparam logic [4:0] RST_CYC = 5'((RST_NS * PCLK_MHZ + 999) / 1000);
  localparam logic [15:0] PC_RESET = 16'h0110;
  // register offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FSEL = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_PC = 8'h0C;
  localparam logic [7:0] A_WSP = 8'h10;
  localparam logic [7:0] A_NSP = 8'h14;
  localparam logic [7:0] A_XREG = 8'h18;
  // control reset: option 4, hold on, pull-down on
  localparam logic [1:0] OPT_RESET = 2'h3;
  localparam logic HOLD_RESET = 1'b1;
  localparam logic PD_RESET = 1'b1;
  // combination options
  localparam logic [1:0] OPT_OFF = 2'h0;
  localparam logic [1:0] OPT_TWO = 2'h1;
  localparam logic [1:0] OPT_THREE = 2'h2;
  // function select bits
  localparam int FS_TMA = 0;
  localparam int FS_TMB = 1;
  localparam int FS_BUZ = 2;
  localparam int FS_FO = 3;
  localparam int FS_EVA = 4;
  localparam int FS_EVB = 5;
  localparam int FS_SW = 6;
  localparam int FS_SIF = 7;
  localparam int FS_MST = 8;
  localparam int FS_RFC = 9;
  // pin index = port * 4 + pin
  localparam int PORT0_PIN0 = 0;
  localparam int PORT0_PIN1 = 1;
  localparam int P10 = 4;
  localparam int P11 = 5;
  localparam int P12 = 6;
  localparam int P13 = 7;
  localparam int P22 = 10;
  localparam int P23 = 11;
  localparam int P30 = 12;
  localparam int P31 = 13;
  localparam int P32 = 14;
  localparam int P33 = 15;
  localparam int P50 = 20;
  localparam int P51 = 21;
  localparam int P52 = 22;
  localparam int P53 = 23;
  // sequencer states
  typedef enum logic [1:0] {ST_RESET = 2'h0, ST_INIT = 2'h1, ST_RUN = 2'h3} kcr_state_type;
endpackage : kcr_pkg

// file: hw/kcr_top.sv
// kcr_top: initial reset sequencer with key-combination reset,
// cpu reset values, stack-pointer interrupt mask and pin muxing
// assumes an APB master on pclk and asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module kcr_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic osc_clk_in,
  input wire logic reset_pin_in,
  input wire logic [23:0] pin_in,
  output logic [23:0] pin_out,
  output logic [23:0] pin_oe,
  output logic [23:0] pin_pd,
  // peripheral outputs to route
  input wire logic timer_a_output,
  input wire logic timer_b_output,
  input wire logic buzzer_output,
  input wire logic clock_output,
  input wire logic serial_clk_out,
  input wire logic serial_data_out,
  input wire logic serial_slave_ready,
  input wire logic rfc_drive_output,
  input wire logic rfc_sensor_pin,
  input wire logic rfc_reference_pin,
  // peripheral inputs from pins
  output logic event_input_a,
  output logic event_input_b,
  output logic stopwatch_run_input,
  output logic stopwatch_lap_input,
  output logic serial_clk_in,
  output logic serial_data_in,
  output logic serial_select_in,
  output logic rfc_oscillation_input,
  // cpu side
  input wire logic instr_retire,
  output logic init_reset,
  output logic cpu_run,
  output logic [15:0] pc_value,
  output logic int_mask,
  output logic extended_mode
);

  // all state of the block
  typedef struct packed {
    logic [23:0] pin_s1; // first sync stage
    logic [23:0] pin_s2; // second sync stage
    logic [2:0] osc_s; // osc sync and edge delay
    logic [1:0] rpin_s; // reset pin sync
    logic [4:0] rcnt; // reset pin width count
    logic pin_ok; // qualified pin request
    logic [10:0] div; // 16 Hz divider
    logic p16; // 16 Hz pulse
    logic [5:0] filt; // noise filter count
    logic key_ok; // filtered combo
    logic [4:0] hold; // hold qualifier count
    logic latch; // reset request latch
    kcr_pkg::kcr_state_type st;
    logic [14:0] icnt; // init period count
    logic [15:0] pc;
    logic iflag;
    logic eflag;
    logic wsp_set; // wide stack pointer written
    logic nsp_set; // nibble stack pointer written
    logic [7:0] wsp; // wide_stack_pointer
    logic [7:0] nsp; // nibble_stack_pointer
    logic [7:0] xreg; // extension_register
    logic [1:0] opt; // combination option
    logic hold_en;
    logic pd_opt;
    logic [9:0] fsel; // pin function select
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic init_rst;
    logic run;
    logic imask;
    logic [23:0] pout;
    logic [23:0] poe;
    logic [23:0] ppd;
    logic [7:0] fwd; // pin values to peripherals
  } kcr_regs_type;

  kcr_regs_type s_q;
  kcr_regs_type s_d;
  logic tick; // osc rising edge
  logic hit; // combination matched
  logic key_req; // qualified key request
  logic req; // any reset request
  logic rst_now; // cpu held in reset
  logic acc; // apb access phase
  logic wr_ok; // write completes
  logic [31:0] rd; // read mux

  // selected pins all high, others ignored
  function automatic logic combo_hit(input logic [1:0] o, input logic [3:0] k);
    unique case (o)
      kcr_pkg::OPT_OFF: combo_hit = 1'b0;
      kcr_pkg::OPT_TWO: combo_hit = &k[1:0];
      kcr_pkg::OPT_THREE: combo_hit = &k[2:0];
      default: combo_hit = &k;
    endcase
  endfunction : combo_hit

  // mapped register check
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == kcr_pkg::A_CTRL) || (a == kcr_pkg::A_FSEL) || (a == kcr_pkg::A_STAT) ||
      (a == kcr_pkg::A_PC) || (a == kcr_pkg::A_WSP) || (a == kcr_pkg::A_NSP) || (a == kcr_pkg::A_XREG);
  endfunction : addr_ok

  // next-state logic
  always_comb begin
    s_d = s_q;
    // synchronisers
    s_d.pin_s1 = pin_in;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.osc_s = {s_q.osc_s[1:0], osc_clk_in};
    s_d.rpin_s = {s_q.rpin_s[0], reset_pin_in};
    tick = s_q.osc_s[1] & ~s_q.osc_s[2];
    // 16 Hz pulse from the oscillator
    s_d.p16 = 1'b0;
    if (tick) begin
      if (s_q.div == kcr_pkg::DIV_LAST) begin
        s_d.div = '0;
        s_d.p16 = 1'b1;
      end else begin
        s_d.div = s_q.div + 11'h001;
      end
    end
    // reset pin: short pulses rejected
    if (!s_q.rpin_s[1]) begin
      s_d.rcnt = '0;
    end else if (s_q.rcnt != kcr_pkg::RST_CYC) begin
      s_d.rcnt = s_q.rcnt + 5'h01;
    end
    s_d.pin_ok = s_q.rpin_s[1] && (s_q.rcnt == kcr_pkg::RST_CYC);
    // key combination noise filter, counts osc edges only
    hit = combo_hit(s_q.opt, s_q.pin_s2[3:0]);
    if (!hit) begin
      s_d.filt = '0;
    end else if (tick && s_q.filt != kcr_pkg::FILT_TICKS) begin
      s_d.filt = s_q.filt + 6'h01;
    end
    s_d.key_ok = hit && (s_q.filt == kcr_pkg::FILT_TICKS);
    // hold qualifier counts 16 Hz pulses
    if (!s_q.key_ok) begin
      s_d.hold = '0;
    end else if (s_q.p16 && s_q.hold != kcr_pkg::HOLD_PULSES) begin
      s_d.hold = s_q.hold + 5'h01;
    end
    key_req = s_q.key_ok && (!s_q.hold_en || s_q.hold == kcr_pkg::HOLD_PULSES);
    req = s_q.pin_ok || key_req;
    // latch: set on request, freed on 16 Hz pulse
    if (req) begin
      s_d.latch = 1'b1;
    end else if (s_q.p16) begin
      s_d.latch = 1'b0;
    end
    // sequencer
    unique case (s_q.st)
      kcr_pkg::ST_RESET: begin
        if (!s_q.latch) begin
          s_d.st = kcr_pkg::ST_INIT;
          s_d.icnt = '0;
        end
      end
      kcr_pkg::ST_INIT: begin
        if (tick) begin
          if (s_q.icnt == kcr_pkg::INIT_LAST) begin
            s_d.st = kcr_pkg::ST_RUN;
          end else begin
            s_d.icnt = s_q.icnt + 15'h0001;
          end
        end
      end
      kcr_pkg::ST_RUN: begin
        s_d.st = kcr_pkg::ST_RUN;
      end
      default: begin
        s_d.st = kcr_pkg::ST_RESET;
      end
    endcase
    if (s_q.latch) begin
      s_d.st = kcr_pkg::ST_RESET;
    end
    rst_now = s_q.latch || (s_q.st != kcr_pkg::ST_RUN);
    // apb: one wait cycle, answer from flops
    acc = psel && penable;
    wr_ok = acc && s_q.pready && pwrite;
    s_d.pready = acc && !s_q.pready;
    s_d.pslverr = acc && !s_q.pready && !addr_ok(paddr);
    unique case (paddr)
      kcr_pkg::A_CTRL: rd = {27'h0, s_q.iflag, s_q.pd_opt, s_q.hold_en, s_q.opt};
      kcr_pkg::A_FSEL: rd = {22'h0, s_q.fsel};
      kcr_pkg::A_STAT: rd = {22'h0, s_q.nsp_set, s_q.wsp_set, s_q.eflag, s_q.iflag, s_q.imask,
                             s_q.pin_ok, s_q.key_ok, s_q.latch, s_q.st};
      kcr_pkg::A_PC: rd = {16'h0, s_q.pc};
      kcr_pkg::A_WSP: rd = {24'h0, s_q.wsp};
      kcr_pkg::A_NSP: rd = {24'h0, s_q.nsp};
      kcr_pkg::A_XREG: rd = {24'h0, s_q.xreg};
      default: rd = '0;
    endcase
    s_d.prdata = (acc && !s_q.pready) ? rd : '0;
    // extension flag ends after the next instruction
    if (instr_retire) begin
      s_d.eflag = 1'b0;
    end
    // register writes
    if (wr_ok) begin
      unique case (paddr)
        kcr_pkg::A_CTRL: begin
          s_d.opt = pwdata[1:0];
          s_d.hold_en = pwdata[2];
          s_d.pd_opt = pwdata[3];
          s_d.iflag = pwdata[4];
        end
        kcr_pkg::A_FSEL: s_d.fsel = pwdata[9:0];
        kcr_pkg::A_WSP: begin
          s_d.wsp = pwdata[7:0];
          s_d.wsp_set = 1'b1;
          if (s_q.wsp_set && s_q.nsp_set) begin
            s_d.nsp_set = 1'b0;
          end
        end
        kcr_pkg::A_NSP: begin
          s_d.nsp = pwdata[7:0];
          s_d.nsp_set = 1'b1;
          if (s_q.wsp_set && s_q.nsp_set) begin
            s_d.wsp_set = 1'b0;
          end
        end
        kcr_pkg::A_XREG: begin
          s_d.xreg = pwdata[7:0];
          s_d.eflag = 1'b1;
        end
        default: begin
          s_d.xreg = s_q.xreg;
        end
      endcase
    end
    // cpu reset values
    if (rst_now) begin
      s_d.pc = kcr_pkg::PC_RESET;
      s_d.iflag = 1'b0;
      s_d.eflag = 1'b0;
      s_d.wsp_set = 1'b0;
      s_d.nsp_set = 1'b0;
      s_d.fsel = '0;
    end
    s_d.init_rst = rst_now;
    s_d.run = !rst_now;
    s_d.imask = rst_now || !(s_q.wsp_set && s_q.nsp_set);
    // pin multiplexer, inputs only while in reset
    s_d.pout = '0;
    s_d.poe = '0;
    s_d.fwd = '0;
    if (!rst_now) begin
      s_d.poe[kcr_pkg::P11] = s_q.fsel[kcr_pkg::FS_TMA];
      s_d.pout[kcr_pkg::P11] = timer_a_output;
      s_d.poe[kcr_pkg::P23] = s_q.fsel[kcr_pkg::FS_TMB];
      s_d.pout[kcr_pkg::P23] = timer_b_output;
      s_d.poe[kcr_pkg::P12] = s_q.fsel[kcr_pkg::FS_BUZ];
      s_d.pout[kcr_pkg::P12] = buzzer_output;
      s_d.poe[kcr_pkg::P13] = s_q.fsel[kcr_pkg::FS_FO];
      s_d.pout[kcr_pkg::P13] = clock_output;
      // serial: clock out as master, ready out as slave
      s_d.poe[kcr_pkg::P30] = s_q.fsel[kcr_pkg::FS_SIF] && s_q.fsel[kcr_pkg::FS_MST];
      s_d.pout[kcr_pkg::P30] = serial_clk_out;
      s_d.poe[kcr_pkg::P31] = s_q.fsel[kcr_pkg::FS_SIF];
      s_d.pout[kcr_pkg::P31] = serial_data_out;
      s_d.poe[kcr_pkg::P33] = s_q.fsel[kcr_pkg::FS_SIF] && !s_q.fsel[kcr_pkg::FS_MST];
      s_d.pout[kcr_pkg::P33] = serial_slave_ready;
      // converter drive pins
      s_d.poe[kcr_pkg::P50] = s_q.fsel[kcr_pkg::FS_RFC];
      s_d.pout[kcr_pkg::P50] = rfc_drive_output;
      s_d.poe[kcr_pkg::P51] = s_q.fsel[kcr_pkg::FS_RFC];
      s_d.pout[kcr_pkg::P51] = rfc_sensor_pin;
      s_d.poe[kcr_pkg::P52] = s_q.fsel[kcr_pkg::FS_RFC];
      s_d.pout[kcr_pkg::P52] = rfc_reference_pin;
      // inputs forwarded to peripherals
      s_d.fwd[0] = s_q.fsel[kcr_pkg::FS_EVA] && s_q.pin_s2[kcr_pkg::P10];
      s_d.fwd[1] = s_q.fsel[kcr_pkg::FS_EVB] && s_q.pin_s2[kcr_pkg::P22];
      s_d.fwd[2] = s_q.fsel[kcr_pkg::FS_SW] && s_q.pin_s2[kcr_pkg::PORT0_PIN0];
      s_d.fwd[3] = s_q.fsel[kcr_pkg::FS_SW] && s_q.pin_s2[kcr_pkg::PORT0_PIN1];
      s_d.fwd[4] = s_q.fsel[kcr_pkg::FS_SIF] && !s_q.fsel[kcr_pkg::FS_MST] && s_q.pin_s2[kcr_pkg::P30];
      s_d.fwd[5] = s_q.fsel[kcr_pkg::FS_SIF] && s_q.pin_s2[kcr_pkg::P32];
      s_d.fwd[6] = s_q.fsel[kcr_pkg::FS_SIF] && !s_q.fsel[kcr_pkg::FS_MST] && s_q.pin_s2[kcr_pkg::P33];
      s_d.fwd[7] = s_q.fsel[kcr_pkg::FS_RFC] && s_q.pin_s2[kcr_pkg::P53];
    end
    // pull-downs on every pin not driven
    s_d.ppd = {24{s_q.pd_opt}} & ~s_d.poe;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.latch <= 1'b1;
      s_q.st <= kcr_pkg::ST_RESET;
      s_q.pc <= kcr_pkg::PC_RESET;
      s_q.opt <= kcr_pkg::OPT_RESET;
      s_q.hold_en <= kcr_pkg::HOLD_RESET;
      s_q.pd_opt <= kcr_pkg::PD_RESET;
      s_q.ppd <= {24{kcr_pkg::PD_RESET}};
      s_q.init_rst <= 1'b1;
      s_q.imask <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign pin_out = s_q.pout;
  assign pin_oe = s_q.poe;
  assign pin_pd = s_q.ppd;
  assign event_input_a = s_q.fwd[0];
  assign event_input_b = s_q.fwd[1];
  assign stopwatch_run_input = s_q.fwd[2];
  assign stopwatch_lap_input = s_q.fwd[3];
  assign serial_clk_in = s_q.fwd[4];
  assign serial_data_in = s_q.fwd[5];
  assign serial_select_in = s_q.fwd[6];
  assign rfc_oscillation_input = s_q.fwd[7];
  assign init_reset = s_q.init_rst;
  assign cpu_run = s_q.run;
  assign pc_value = s_q.pc;
  assign int_mask = s_q.imask;
  assign extended_mode = s_q.eflag;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_combo_match: assert property (s_q.key_ok |-> combo_hit($past(s_q.opt), $past(s_q.pin_s2[3:0])))
    else $error("key filter passed without combination");
  chk_filter_len: assert property ($rose(s_q.key_ok) |-> $past(s_q.filt) == kcr_pkg::FILT_TICKS)
    else $error("key filter length wrong");
  chk_option_off: assert property (s_q.opt == kcr_pkg::OPT_OFF |-> ##1 !s_q.key_ok)
    else $error("disabled option produced key request");
  chk_hold_time: assert property (s_q.hold_en && s_q.key_ok && !s_q.pin_ok && !s_q.latch &&
                                  s_q.hold != kcr_pkg::HOLD_PULSES |=> !s_q.latch)
    else $error("reset before hold time");
  chk_req_latch: assert property (s_q.pin_ok |=> s_q.latch ##1 (s_q.latch || $past(s_q.p16)))
    else $error("pin request did not latch");
  chk_latch_free: assert property ($fell(s_q.latch) |-> $past(s_q.p16))
    else $error("latch freed off the 16 Hz pulse");
  chk_init_len: assert property ($rose(s_q.run) |-> $past(s_q.icnt, 2) == kcr_pkg::INIT_LAST)
    else $error("init period wrong length");
  chk_pc_vector: assert property (init_reset |-> pc_value == kcr_pkg::PC_RESET)
    else $error("pc not at reset vector");
  chk_flags_clr: assert property ($rose(cpu_run) |-> !extended_mode && !s_q.iflag)
    else $error("flags not cleared by reset");
  chk_sp_mask: assert property (!(s_q.wsp_set && s_q.nsp_set) |=> int_mask)
    else $error("interrupts unmasked before stack pointers");
  chk_xreg_flag: assert property (!rst_now && wr_ok && paddr == kcr_pkg::A_XREG |=> extended_mode)
    else $error("extension write did not set flag");
  chk_gpio_reset: assert property (init_reset |-> pin_oe == '0 && pin_pd == {24{$past(s_q.pd_opt)}})
    else $error("pins not plain inputs in reset");
  chk_serial_pin: assert property (!rst_now && s_q.fsel[kcr_pkg::FS_SIF] && s_q.fsel[kcr_pkg::FS_MST]
                                   |=> pin_oe[kcr_pkg::P30] && pin_oe[kcr_pkg::P31])
    else $error("serial master pins not driven");
  chk_timer_pin: assert property (!rst_now && s_q.fsel[kcr_pkg::FS_TMA]
                                  |=> pin_out[kcr_pkg::P11] == $past(timer_a_output))
    else $error("timer a not on its pin");
  cov_key_reset: cover property (s_q.key_ok ##1 s_q.latch);
  cov_run: cover property ($rose(cpu_run));
  cov_sp_pair: cover property ($fell(int_mask) && cpu_run);
endmodule : kcr_top
`default_nettype wire

// file: tb/kcr_key_model.sv
// kcr_key_model: keys on the port0 group and the free-running oscillator
// assumes the bench sets the key pattern and the other pin levels
`timescale 1ns/1ps
`default_nettype none
module kcr_key_model (
  // bench commands
  input wire logic [3:0] keys,
  input wire logic [19:0] idle_pins,
  // pins toward the device
  output logic osc_clk_in,
  output logic [23:0] pin_in
);
  logic osc_q = 1'b0; // oscillator level, low at time zero
  // oscillator runs free, sped up so the init period fits the run; each 7 ns
  // phase holds at least one pclk edge, and no edge lands on a rising pclk edge
  always #7 osc_q = ~osc_q;
  assign osc_clk_in = osc_q;
  // released keys are driven low from the bench keys input, so no combo in normal use
  assign pin_in = {idle_pins, keys};
endmodule : kcr_key_model
`default_nettype wire

// file: tb/kcr_top_tb.sv
// kcr_top_tb: self-checking bench for the key-combination reset block
// assumes kcr_key_model on the pins and an apb master in this module
`timescale 1ns/1ps
`default_nettype none
module kcr_top_tb;
  // clock, reset and apb master signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // pins and cpu side
  logic osc_clk_in;
  logic reset_pin_in = 1'b0;
  logic [23:0] pin_in, pin_out, pin_oe, pin_pd;
  logic [9:0] periph = 10'h000;
  logic instr_retire = 1'b0;
  logic init_reset, cpu_run, int_mask, extended_mode, sdi;
  logic [15:0] pc_value;
  logic [3:0] keys = 4'h0;
  logic [19:0] idle_pins = 20'h00000;
  // noted read results and the counters
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  logic [32:0] mon_e, mon_m;
  int num_errors = 0;
  int n_checks = 0;

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  kcr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_clk_in(osc_clk_in), .reset_pin_in(reset_pin_in), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pd(pin_pd), .timer_a_output(periph[0]), .timer_b_output(periph[1]),
    .buzzer_output(periph[2]), .clock_output(periph[3]), .serial_clk_out(periph[4]),
    .serial_data_out(periph[5]), .serial_slave_ready(periph[6]), .rfc_drive_output(periph[7]),
    .rfc_sensor_pin(periph[8]), .rfc_reference_pin(periph[9]), .event_input_a(),
    .event_input_b(), .stopwatch_run_input(), .stopwatch_lap_input(), .serial_clk_in(),
    .serial_data_in(sdi), .serial_select_in(), .rfc_oscillation_input(),
    .instr_retire(instr_retire), .init_reset(init_reset), .cpu_run(cpu_run),
    .pc_value(pc_value), .int_mask(int_mask), .extended_mode(extended_mode));

  kcr_key_model keys_far (.keys(keys), .idle_pins(idle_pins), .osc_clk_in(osc_clk_in),
    .pin_in(pin_in));

  // compare one value and count it
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // counts, verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  // one apb transfer; a read notes {pslverr, prdata} and a mask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m, output logic [31:0] r);
    @(posedge pclk);
    if (!wr) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, 33'h0, 33'h0, r);
  endtask : wr

  // register read with expected value under a mask
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, e, m, r);
  endtask : rd

  // poll status until the reset latch has let go
  task automatic wait_free();
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      apb(1'b0, kcr_pkg::A_STAT, 32'h0, 33'h0, 33'h0, r);
      n++;
    end while (r[2] !== 1'b0 && n < 8000);
    check(33'(r[2]), 33'h0);
    rd(kcr_pkg::A_STAT, 33'h1, 33'h1_0000_0003);
    check({31'h0, cpu_run, init_reset}, 33'h1);
  endtask : wait_free

  // let oscillator edges pass, then return on a pclk edge
  task automatic wait_osc(input int n);
    repeat (n) @(posedge osc_clk_in);
    @(posedge pclk);
  endtask : wait_osc

  // watcher: takes the oldest note whenever a read completes
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      mon_m = msk_q.pop_front();
      if (mon_m != 33'h0) begin
        check({pslverr, prdata} & mon_m, mon_e & mon_m);
      end
    end
  end

  // watchdog sized for about 86k cycles of tests
  initial begin
    repeat (150000) @(posedge pclk);
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out();
  end

  // main sequence
  initial begin
    logic [3:0] sel;
    void'($urandom(77));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // pins and cpu state straight after reset
    check(33'(pin_oe), 33'h0);
    check(33'(pin_pd), 33'h0_00FF_FFFF);
    check(33'(pc_value), 33'h0110);
    check({30'h0, init_reset, int_mask, extended_mode}, 33'h6);
    rd(kcr_pkg::A_CTRL, 33'h0_0000_000F, 33'h1_0000_001F);
    wr(kcr_pkg::A_PC, 32'h0000_1234);
    rd(kcr_pkg::A_PC, 33'h0_0000_0110, 33'h1_0000_FFFF);
    rd(kcr_pkg::A_STAT, 33'h0_0000_0024, 33'h1_0000_00E7);
    rd(8'h40, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
    $display("test reset values done");
    wait_free();
    // pull-down off for the reset-state inputs
    wr(kcr_pkg::A_CTRL, 32'h0000_0003);
    repeat (3) @(posedge pclk);
    check(33'(pin_pd), 33'h0);
    $display("test latch release and pull-down done");
    // cpu side once the init period is over
    wait (cpu_run === 1'b1);
    @(posedge pclk);
    check({30'h0, init_reset, int_mask, extended_mode}, 33'h2);
    rd(kcr_pkg::A_STAT, 33'h0_0000_0023, 33'h1_0000_03E7);
    // stack pointers written as a pair, then each re-written in turn
    wr(kcr_pkg::A_WSP, 32'h0000_00A5);
    rd(kcr_pkg::A_WSP, 33'h0_0000_00A5, 33'h1_0000_00FF);
    check(33'(int_mask), 33'h1);
    wr(kcr_pkg::A_NSP, 32'h0000_003C);
    repeat (2) @(posedge pclk);
    check(33'(int_mask), 33'h0);
    wr(kcr_pkg::A_WSP, 32'h0000_005A);
    repeat (2) @(posedge pclk);
    check(33'(int_mask), 33'h1);
    wr(kcr_pkg::A_NSP, 32'h0000_00C3);
    repeat (2) @(posedge pclk);
    check(33'(int_mask), 33'h0);
    // extension write sets the flag, next instruction clears it
    wr(kcr_pkg::A_XREG, 32'h0000_0077);
    @(posedge pclk);
    check(33'(extended_mode), 33'h1);
    instr_retire <= 1'b1;
    @(posedge pclk);
    instr_retire <= 1'b0;
    @(posedge pclk);
    check(33'(extended_mode), 33'h0);
    // timer a plus serial master routed to their pins
    idle_pins <= 20'($urandom());
    periph <= 10'($urandom());
    wr(kcr_pkg::A_FSEL, 32'h0000_0181);
    repeat (3) @(posedge pclk);
    check(33'(pin_oe), 33'h0_0000_3020);
    check(33'(pin_out[kcr_pkg::P11]), 33'(periph[0]));
    check(33'(sdi), 33'(idle_pins[kcr_pkg::P32 - 4]));
    // hold qualifier on: a short combination must not reset
    wr(kcr_pkg::A_CTRL, 32'h0000_000F);
    keys <= 4'hF;
    wait_osc(60);
    rd(kcr_pkg::A_STAT, 33'h0_0000_0008, 33'h0_0000_000C);
    keys <= 4'h0;
    wait_osc(2);
    $display("test cpu side done");
    // every combination option, hold qualifier off
    for (int opt = 0; opt < 4; opt++) begin
      sel = (opt == 0) ? 4'h0 : 4'((1 << (opt + 1)) - 1);
      wr(kcr_pkg::A_CTRL, 32'h8 | 32'(opt));
      idle_pins <= 20'($urandom());
      periph <= 10'($urandom());
      instr_retire <= 1'($urandom());
      keys <= (sel >> 1) | (4'($urandom()) & ~sel);
      wait_osc(60);
      rd(kcr_pkg::A_STAT, 33'h0, 33'h4);
      keys <= (opt == 0) ? 4'hF : (sel | (4'($urandom()) & ~sel));
      wait_osc(60);
      rd(kcr_pkg::A_STAT, (opt == 0) ? 33'h0 : 33'h4, 33'h4);
      check(33'(init_reset), (opt == 0) ? 33'h0 : 33'h1);
      keys <= 4'h0;
      if (opt != 0) begin
        wait_free();
      end
      $display("test option %0d done", opt);
    end
    // reset pin alone raises the same latch
    reset_pin_in <= 1'b1;
    repeat (30) @(posedge pclk);
    rd(kcr_pkg::A_STAT, 33'h4, 33'h1_0000_0007);
    reset_pin_in <= 1'b0;
    wait_free();
    $display("test reset pin done");
    close_out();
  end
endmodule : kcr_top_tb
`default_nettype wire
